// ### src/drdsi_defs.svh
// Offsets, field positions, reset values and timing counts of the dual-rank link.
// Assumes it is included by bare name in every file that needs the numbers.
`ifndef DRDSI_DEFS_SVH
`define DRDSI_DEFS_SVH
// System clock and link clock periods in ns
`define DRDSI_CLK_NS 40
`define DRDSI_LINK_NS 320
// System cycles per link half period
`define DRDSI_HALF_CYC (`DRDSI_LINK_NS / (2 * `DRDSI_CLK_NS))
// Address bit positions
`define DRDSI_A_AP 10
`define DRDSI_A_BC 12
`define DRDSI_A_INTLV 3
`define DRDSI_A_RTT0 2
`define DRDSI_A_RTT1 6
`define DRDSI_A_RTT2 9
`define DRDSI_A_TDQS 11
// Burst length field codes
`define DRDSI_BL_FIX8 2'h0
`define DRDSI_BL_OTF 2'h1
`define DRDSI_BL_FIX4 2'h2
// Last beat index of a full and a chopped burst
`define DRDSI_LAST8 3'h7
`define DRDSI_LAST4 3'h3
// Mode reset values
`define DRDSI_BL_RST 2'h0
`define DRDSI_ODTEN_RST 1'b1
`define DRDSI_TDQS_RST 1'b0
// Controller register offsets
`define DRDSI_OFF_CTRL 8'h00
`define DRDSI_OFF_ADDR 8'h04
`define DRDSI_OFF_WDLO 8'h08
`define DRDSI_OFF_WDHI 8'h0c
`define DRDSI_OFF_MASK 8'h10
`define DRDSI_OFF_CFG 8'h14
`define DRDSI_OFF_STAT 8'h18
`define DRDSI_OFF_RDLO 8'h1c
`define DRDSI_OFF_RDHI 8'h20
// AXI responses
`define DRDSI_RESP_OK 2'h0
`define DRDSI_RESP_ERR 2'h2
`endif

// ### src/drdsi_pkg.sv
// Types shared by both ends of the dual-rank link.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package drdsi_pkg;
  // Command code is {rasN, casN, weN} while a chip select is low
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR = 3'b100,
    CMD_RD = 3'b101,
    CMD_ZQ = 3'b110,
    CMD_NOP = 3'b111
  } drdsi_cmd_t;
  // Device burst engine
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_RWAIT = 2'b01,
    D_RBURST = 2'b10,
    D_WBURST = 2'b11
  } drdsi_dst_t;
  // Controller link sequencer
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_CMD = 2'b01,
    C_WDAT = 2'b10,
    C_RDAT = 2'b11
  } drdsi_cst_t;
endpackage
`default_nettype wire

// ### src/drdsi_if.sv
// Pin bundle between the controller end and the memory end.
// Assumes each two-way pin is resolved here from the two enables.
`timescale 1ns/1ps
`default_nettype none
interface drdsi_if;
  logic ck;             // Link clock, made by the controller
  logic ckN;            // Complement clock
  logic [1:0] csN;      // One select per rank
  logic rasN;
  logic casN;
  logic weN;
  logic [2:0] ba;
  logic [15:0] addr;
  logic [1:0] odt;      // One termination control per rank
  logic dm;             // Write mask, input-only at the memory
  logic [7:0] dqC;      // Controller data drive and enables
  logic [7:0] dqCOe;
  logic [7:0] dqD;      // Memory data drive and enables
  logic [7:0] dqDOe;
  logic dqsC;
  logic dqsCOe;
  logic dqsD;
  logic dqsDOe;
  logic [7:0] dq;       // Resolved wire levels
  logic dqs;
  logic dqsN;
  // Undriven dq and dqs settle low; dqsN then sits high
  assign ckN = ~ck;
  assign dq = (dqD & dqDOe) | (dqC & dqCOe & ~dqDOe);
  assign dqs = dqsDOe ? dqsD : (dqsCOe & dqsC);
  assign dqsN = ~dqs;
  modport dev (input ck, ckN, csN, rasN, casN, weN, ba, addr, odt, dm, dq, dqs, dqsN,
               output dqD, dqDOe, dqsD, dqsDOe);
  modport ctrl (output ck, csN, rasN, casN, weN, ba, addr, odt, dm, dqC, dqCOe, dqsC, dqsCOe,
                input dq, dqs);
endinterface
`default_nettype wire

// ### src/drdsi_device.sv
// Memory end of the dual-rank link: two ranks of eight banks with burst data.
// Assumes the link clock and all pins arrive from outside the clk domain.
// Operation
// - Rank ignores commands while its select high
// - Controller picks rank by its own select
// - Command decoded from select, RAS, CAS, WE
// - Masked write beats leave memory unchanged
// - Termination follows registered control input level
// - Termination covers data, strobes and mask only
// - Mode-disabled termination ignores its control input
// - Reset asserts and releases asynchronously, active low
// - Read strobe edges coincide with data edges
// - Controller centres write strobe in each beat
// - Wide termination strobe disables mask, terminates
// - Wide variant adds inverted strobe, upper nibble
// - Eight-word prefetch: eight beats, two per clock
// - Bursts run from start column in programmed order
// - Controller activates row before read or write
// - Activate picks bank and row from address
// - Read/write picks rank, bank, start column
// - Two independent ranks of eight banks each
// - Command, address and termination inputs sampled at rising link clock edge; data and mask at each strobe edge
// - Bit 12 selects full or chopped burst
// - Bit 10 closes one/all banks, or auto-closes
`timescale 1ns/1ps
`default_nettype none
`include "drdsi_defs.svh"
module drdsi_device #(
  parameter int WIDE = 1,
  parameter int ROWB = 3,
  parameter int COLB = 4,
  parameter int RL = 2
) (
  input wire logic clk,
  input wire logic nrst,
  drdsi_if.dev link,
  output logic [1:0] termDq,
  output logic [1:0] termDm,
  output logic [1:0] termTdqs
);
  import drdsi_pkg::*;
  localparam int SW = 37;                       // Width of the sampled pin bundle
  localparam int MEMN = 16 << (ROWB + COLB);    // Two ranks, eight banks each
  localparam logic [7:0] DQ_EN = (WIDE != 0) ? 8'hff : 8'h0f;
  localparam logic WIDE1 = (WIDE != 0);
  localparam logic [3:0] RLW = 4'(RL);

  // Column of a given beat: wraps inside the aligned group of eight
  function automatic logic [2:0] beatCol(input logic [2:0] c, input logic [2:0] b,
                                         input logic il);
    beatCol = il ? (c ^ b) : 3'(c + b);
  endfunction

  logic [SW-1:0] pinV;
  logic [SW-1:0] s1_q;         // First stage, read only by s2_q
  logic [SW-1:0] s2_q;
  logic ck3_q;                 // Delayed copies for edge finding
  logic dqs3_q;
  logic ckS, dqsS, dmS;
  logic [1:0] csS, odtS;
  logic [2:0] baS;
  logic [15:0] aS;
  logic [7:0] dqS;
  drdsi_cmd_t cmd;
  logic ckRise, ckEdge, dqsEdge;
  logic [1:0] rankHit;
  logic rkSel;
  logic [3:0] bkIdx;
  logic [2:0] lastSel;
  logic canGo, goRd, goWr;
  // Per bank and per rank state
  logic rowOpen_q [16];
  logic [ROWB-1:0] openRow_q [16];
  logic [1:0] blMode_q [2];
  logic intlv_q [2];
  logic odtEn_q [2];
  logic tdqs_q [2];
  // Burst engine
  drdsi_dst_t st_q;
  logic [2:0] beat_q, bLast_q, bBank_q, nxtBeat;
  logic [3:0] wait_q;
  logic bRank_q, bIl_q;
  logic [ROWB-1:0] bRow_q;
  logic [COLB-1:0] bCol_q;
  logic [7:0] mem_q [MEMN];
  logic [3+ROWB+COLB:0] rIdx, wIdx;
  logic dmEn, wrBeat;
  logic [7:0] dqD_q, dqDOe_q;
  logic dqsD_q, dqsDOe_q;

  // Every pin crosses two flops before anything looks at it
  assign pinV = {link.ck, link.csN, link.rasN, link.casN, link.weN, link.ba, link.addr,
                 link.odt, link.dqs, link.dm, link.dq};
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      ck3_q <= 1'b0;
      dqs3_q <= 1'b0;
    end else begin
      s1_q <= pinV;
      s2_q <= s1_q;
      ck3_q <= ckS;
      dqs3_q <= dqsS;
    end
  end

  assign ckS = s2_q[36];
  assign csS = s2_q[35:34];
  assign cmd = drdsi_cmd_t'(s2_q[33:31]);
  assign baS = s2_q[30:28];
  assign aS = s2_q[27:12];
  assign odtS = s2_q[11:10];
  assign dqsS = s2_q[9];
  assign dmS = s2_q[8];
  assign dqS = s2_q[7:0];
  // Command and address are taken only at the rising link edge
  assign ckRise = ckS & ~ck3_q;
  assign ckEdge = ckS ^ ck3_q;
  assign dqsEdge = dqsS ^ dqs3_q;
  // A rank listens only while its own select is low
  assign rankHit = ~csS & {2{ckRise}};
  assign rkSel = csS[0];
  assign bkIdx = {rkSel, baS};
  // Burst length from mode, or from bit 12 when chosen on the fly
  assign lastSel = ((blMode_q[rkSel] == `DRDSI_BL_FIX4) ||
                    ((blMode_q[rkSel] == `DRDSI_BL_OTF) && !aS[`DRDSI_A_BC]))
                   ? `DRDSI_LAST4 : `DRDSI_LAST8;
  // A closed bank drops the access; a burst in flight blocks a new one
  assign canGo = (st_q == D_IDLE) && (|rankHit) && rowOpen_q[bkIdx];
  assign goRd = canGo && (cmd == CMD_RD);
  assign goWr = canGo && (cmd == CMD_WR);

  // Mode registers and open rows, kept apart for each rank and bank
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 16; i++) begin
        rowOpen_q[i] <= 1'b0;
        openRow_q[i] <= '0;
      end
      for (int r = 0; r < 2; r++) begin
        blMode_q[r] <= `DRDSI_BL_RST;
        intlv_q[r] <= 1'b0;
        odtEn_q[r] <= `DRDSI_ODTEN_RST;
        tdqs_q[r] <= `DRDSI_TDQS_RST;
      end
    end else begin
      for (int r = 0; r < 2; r++) begin
        if (rankHit[r]) begin
          if (cmd == CMD_MRS && baS == 3'h0) begin
            blMode_q[r] <= aS[1:0];
            intlv_q[r] <= aS[`DRDSI_A_INTLV];
          end
          if (cmd == CMD_MRS && baS == 3'h1) begin
            // All termination value bits zero turns termination off
            odtEn_q[r] <= aS[`DRDSI_A_RTT0] | aS[`DRDSI_A_RTT1] | aS[`DRDSI_A_RTT2];
            tdqs_q[r] <= aS[`DRDSI_A_TDQS] & WIDE1;
          end
          if (cmd == CMD_ACT) begin
            rowOpen_q[{r[0], baS}] <= 1'b1;
            openRow_q[{r[0], baS}] <= aS[ROWB-1:0];
          end
          // Auto close on access; the burst already holds its row
          if ((cmd == CMD_RD || cmd == CMD_WR) && aS[`DRDSI_A_AP]) begin
            rowOpen_q[{r[0], baS}] <= 1'b0;
          end
          if (cmd == CMD_PRE) begin
            for (int b = 0; b < 8; b++) begin
              if (aS[`DRDSI_A_AP] || baS == 3'(b)) begin
                rowOpen_q[{r[0], 3'(b)}] <= 1'b0;
              end
            end
          end
        end
      end
    end
  end

  // Termination state per rank, updated at each rising link edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      termDq <= 2'b00;
      termDm <= 2'b00;
      termTdqs <= 2'b00;
    end else if (ckRise) begin
      for (int r = 0; r < 2; r++) begin
        termDq[r] <= odtS[r] & odtEn_q[r];
        termDm[r] <= odtS[r] & odtEn_q[r] & ~tdqs_q[r];
        termTdqs[r] <= odtS[r] & odtEn_q[r] & tdqs_q[r];
      end
    end
  end

  // Address of the beat being driven next or being stored now
  assign nxtBeat = (st_q == D_RWAIT) ? 3'h0 : 3'(beat_q + 3'h1);
  assign rIdx = {bRank_q, bBank_q, bRow_q, bCol_q[COLB-1:3], beatCol(bCol_q[2:0], nxtBeat, bIl_q)};
  assign wIdx = {bRank_q, bBank_q, bRow_q, bCol_q[COLB-1:3], beatCol(bCol_q[2:0], beat_q, bIl_q)};
  // Mask only works while the termination strobe is off
  assign dmEn = ~tdqs_q[bRank_q];
  assign wrBeat = (st_q == D_WBURST) && dqsEdge && !(dmS && dmEn);

  // Storage array, no reset: contents are undefined at power-up
  always_ff @(posedge clk) begin
    if (wrBeat) begin
      mem_q[wIdx] <= dqS;
    end
  end

  // Burst engine: one access moves eight beats, or four when chopped, one per link edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= D_IDLE;
      beat_q <= 3'h0;
      wait_q <= 4'h0;
      {bRank_q, bBank_q, bRow_q, bCol_q, bLast_q, bIl_q} <= '0;
      dqD_q <= 8'h00;
      dqDOe_q <= 8'h00;
      dqsD_q <= 1'b0;
      dqsDOe_q <= 1'b0;
    end else begin
      unique case (st_q)
        D_IDLE: begin
          if (goRd || goWr) begin
            bRank_q <= rkSel;
            bBank_q <= baS;
            bRow_q <= openRow_q[bkIdx];
            bCol_q <= aS[COLB-1:0];
            bLast_q <= lastSel;
            bIl_q <= intlv_q[rkSel];
            beat_q <= 3'h0;
            wait_q <= RLW;
            st_q <= goRd ? D_RWAIT : D_WBURST;
          end
        end
        D_RWAIT: begin
          // Read latency counted in rising link edges
          if (ckRise) begin
            if (wait_q <= 4'h1) begin
              st_q <= D_RBURST;
              dqD_q <= mem_q[rIdx];
              dqsD_q <= 1'b1;
              dqDOe_q <= DQ_EN;
              dqsDOe_q <= 1'b1;
            end else begin
              wait_q <= wait_q - 4'h1;
            end
          end
        end
        D_RBURST: begin
          // Data and strobe change on the same edge
          if (ckEdge) begin
            if (beat_q == bLast_q) begin
              st_q <= D_IDLE;
              dqDOe_q <= 8'h00;
              dqsDOe_q <= 1'b0;
            end else begin
              beat_q <= nxtBeat;
              dqD_q <= mem_q[rIdx];
              dqsD_q <= ~dqsD_q;
            end
          end
        end
        D_WBURST: begin
          // Each strobe edge, rising or falling, carries one beat
          if (dqsEdge) begin
            if (beat_q == bLast_q) begin
              st_q <= D_IDLE;
            end else begin
              beat_q <= 3'(beat_q + 3'h1);
            end
          end
        end
      endcase
    end
  end

  assign link.dqD = dqD_q;
  assign link.dqDOe = dqDOe_q;
  assign link.dqsD = dqsD_q;
  assign link.dqsDOe = dqsDOe_q;
endmodule
`default_nettype wire

// ### src/drdsi_ctrl.sv
// Controller end of the dual-rank link, ordered by software over AXI4-Lite.
// Assumes the link makes no clock of its own; ck is divided down from clk.
`timescale 1ns/1ps
`default_nettype none
`include "drdsi_defs.svh"
module drdsi_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  drdsi_if.ctrl link
);
  import drdsi_pkg::*;
  localparam logic [2:0] HALF = 3'(`DRDSI_HALF_CYC);

  // Register bank
  logic [2:0] cmd_q;
  logic rank_q, otf_q, busy_q;
  logic [15:0] addrR_q;
  logic [2:0] bankR_q;
  logic [63:0] wd_q, rd_q;
  logic [7:0] mask_q;
  logic [1:0] odtR_q;
  // AXI write and read channel state
  logic [7:0] aAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic awHeld_q, wHeld_q, awHeld_d, wHeld_d, bvalid_d, rvalid_d;
  logic awTake, wTake, arTake, doWr, goW;
  logic [31:0] wv;

  // Current value of a register, used by reads and by byte merging
  function automatic logic [31:0] regView(input logic [7:0] a);
    case (a)
      `DRDSI_OFF_CTRL: regView = {27'h0, rank_q, 1'b0, cmd_q};
      `DRDSI_OFF_ADDR: regView = {13'h0, bankR_q, addrR_q};
      `DRDSI_OFF_WDLO: regView = wd_q[31:0];
      `DRDSI_OFF_WDHI: regView = wd_q[63:32];
      `DRDSI_OFF_MASK: regView = {24'h0, mask_q};
      `DRDSI_OFF_CFG: regView = {29'h0, otf_q, odtR_q};
      `DRDSI_OFF_STAT: regView = {31'h0, busy_q};
      `DRDSI_OFF_RDLO: regView = rd_q[31:0];
      `DRDSI_OFF_RDHI: regView = rd_q[63:32];
      default: regView = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `DRDSI_OFF_RDHI);
  endfunction

  assign awTake = awvalid & awready;
  assign wTake = wvalid & wready;
  assign arTake = arvalid & arready;
  // A write completes once both address and data are held
  assign doWr = awHeld_q & wHeld_q & ~bvalid;
  assign awHeld_d = ~doWr & (awHeld_q | awTake);
  assign wHeld_d = ~doWr & (wHeld_q | wTake);
  assign bvalid_d = doWr | (bvalid & ~bready);
  assign rvalid_d = arTake | (rvalid & ~rready);
  // Command kick is refused while the previous one still runs
  assign goW = doWr && (aAddr_q == `DRDSI_OFF_CTRL) && !busy_q;
  always_comb begin
    wv = regView(aAddr_q);
    for (int i = 0; i < 4; i++) begin
      if (wStrb_q[i]) begin
        wv[8*i +: 8] = wData_q[8*i +: 8];
      end
    end
  end

  // Bus handshakes: one write and one read at a time
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {awHeld_q, wHeld_q, bvalid, rvalid, awready, wready, arready} <= '0;
      {aAddr_q, wData_q, wStrb_q, bresp, rresp, rdata} <= '0;
    end else begin
      awHeld_q <= awHeld_d;
      wHeld_q <= wHeld_d;
      bvalid <= bvalid_d;
      rvalid <= rvalid_d;
      awready <= ~awHeld_d & ~bvalid_d;
      wready <= ~wHeld_d & ~bvalid_d;
      arready <= ~rvalid_d;
      if (awTake) aAddr_q <= awaddr;
      if (wTake) {wData_q, wStrb_q} <= {wdata, wstrb};
      if (doWr) bresp <= mapped(aAddr_q) ? `DRDSI_RESP_OK : `DRDSI_RESP_ERR;
      if (arTake) begin
        rdata <= regView(araddr);
        rresp <= mapped(araddr) ? `DRDSI_RESP_OK : `DRDSI_RESP_ERR;
      end
    end
  end

  // Software-written registers; status and read data are hardware's
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {cmd_q, rank_q, addrR_q, bankR_q, wd_q, mask_q, odtR_q, otf_q} <= '0;
    end else if (doWr) begin
      case (aAddr_q)
        `DRDSI_OFF_CTRL: if (!busy_q) {rank_q, cmd_q} <= {wv[4], wv[2:0]};
        `DRDSI_OFF_ADDR: {bankR_q, addrR_q} <= wv[18:0];
        `DRDSI_OFF_WDLO: wd_q[31:0] <= wv;
        `DRDSI_OFF_WDHI: wd_q[63:32] <= wv;
        `DRDSI_OFF_MASK: mask_q <= wv[7:0];
        `DRDSI_OFF_CFG: {otf_q, odtR_q} <= wv[2:0];
        default: ;
      endcase
    end
  end

  // Link clock divider: ck toggles every HALF system cycles
  logic [2:0] ckCnt_q;
  logic ck_q, tick, mid, ckFall;
  assign tick = (ckCnt_q == HALF - 3'h1);
  assign mid = (ckCnt_q == (HALF >> 1) - 3'h1);
  assign ckFall = tick & ck_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ckCnt_q <= 3'h0;
      ck_q <= 1'b0;
    end else begin
      ckCnt_q <= tick ? 3'h0 : 3'(ckCnt_q + 3'h1);
      if (tick) ck_q <= ~ck_q;
    end
  end

  // Read return path: pins cross two flops, capture two cycles after an edge
  logic [8:0] rs1_q, rs2_q;
  logic dqs3_q, e1_q, capt_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      {rs1_q, rs2_q, dqs3_q, e1_q, capt_q} <= '0;
    end else begin
      rs1_q <= {link.dqs, link.dq};
      rs2_q <= rs1_q;
      dqs3_q <= rs2_q[8];
      e1_q <= rs2_q[8] ^ dqs3_q;
      capt_q <= e1_q;
    end
  end

  // Link sequencer
  drdsi_cst_t st_q;
  logic [2:0] beat_q, nb, last;
  logic [1:0] csN_q, odt_q;
  logic [2:0] cmdP_q, ba_q;
  logic [15:0] a_q;
  logic [7:0] dqC_q, dqCOe_q;
  logic dm_q, dqsC_q, dqsCOe_q;
  assign nb = 3'(beat_q + 3'h1);
  assign last = (otf_q && !addrR_q[`DRDSI_A_BC]) ? `DRDSI_LAST4 : `DRDSI_LAST8;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= C_IDLE;
      {busy_q, beat_q, rd_q, ba_q, a_q, dqC_q, dqCOe_q, dm_q, dqsC_q, dqsCOe_q} <= '0;
      csN_q <= 2'b11;
      cmdP_q <= CMD_NOP;
      odt_q <= 2'b00;
    end else begin
      odt_q <= odtR_q;
      unique case (st_q)
        C_IDLE: begin
          if (goW) begin
            busy_q <= 1'b1;
          end else if (busy_q && ckFall) begin
            // Change pins at the falling edge so they are steady at the rise
            csN_q <= rank_q ? 2'b01 : 2'b10;
            cmdP_q <= cmd_q;
            ba_q <= bankR_q;
            a_q <= addrR_q;
            st_q <= C_CMD;
          end
        end
        C_CMD: begin
          if (ckFall) begin
            csN_q <= 2'b11;
            cmdP_q <= CMD_NOP;
            beat_q <= 3'h0;
            if (cmd_q == CMD_WR) begin
              st_q <= C_WDAT;
              dqC_q <= wd_q[7:0];
              dm_q <= mask_q[0];
              dqCOe_q <= 8'hff;
              dqsC_q <= 1'b0;
              dqsCOe_q <= 1'b1;
            end else if (cmd_q == CMD_RD) begin
              st_q <= C_RDAT;
            end else begin
              st_q <= C_IDLE;
              busy_q <= 1'b0;
            end
          end
        end
        C_WDAT: begin
          if (mid) begin
            dqsC_q <= ~dqsC_q;
          end else if (tick) begin
            if (beat_q == last) begin
              {dqCOe_q, dqsCOe_q, dm_q} <= '0;
              st_q <= C_IDLE;
              busy_q <= 1'b0;
            end else begin
              beat_q <= nb;
              dqC_q <= wd_q[{nb, 3'h0} +: 8];
              dm_q <= mask_q[nb];
            end
          end
        end
        C_RDAT: begin
          // Waits for the memory's strobes however long they take
          if (capt_q) begin
            rd_q[{beat_q, 3'h0} +: 8] <= rs2_q[7:0];
            if (beat_q == last) begin
              st_q <= C_IDLE;
              busy_q <= 1'b0;
            end else begin
              beat_q <= nb;
            end
          end
        end
      endcase
    end
  end

  assign link.ck = ck_q;
  assign link.csN = csN_q;
  assign {link.rasN, link.casN, link.weN} = cmdP_q;
  assign link.ba = ba_q;
  assign link.addr = a_q;
  assign link.odt = odt_q;
  assign link.dm = dm_q;
  assign link.dqC = dqC_q;
  assign link.dqCOe = dqCOe_q;
  assign link.dqsC = dqsC_q;
  assign link.dqsCOe = dqsCOe_q;
endmodule
`default_nettype wire

// ### sim/drdsi_props.sv
// Watches the pins between the two link ends for protocol slips.
// Assumes it is instantiated beside the link interface, on the system clock.
`timescale 1ns/1ps
`default_nettype none
module drdsi_props (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ck,
  input wire logic [1:0] csN,
  input wire logic [7:0] dq,
  input wire logic dqs,
  input wire logic [7:0] dqDOe,
  input wire logic dqsDOe,
  input wire logic [7:0] dqCOe,
  input wire logic dqsCOe
);
  // One clock domain, so clock and disable are set once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Rank 0 select held for one full link period, then released
  sequence cmdHeld;
    !csN[0] [*8] ##1 csN[0];
  endsequence
  AST_RST_IDLE: assert property ($rose(nrst) |-> csN == 2'b11 && dqDOe == 8'h00 && !dqsDOe)
    else $error("link not idle after reset");
  AST_ONE_RANK: assert property (csN != 2'b00)
    else $error("both ranks selected");
  AST_CMD_LOW: assert property ($fell(csN[0]) |-> !ck)
    else $error("command launched while link clock high");
  AST_CMD_LEN: assert property ($fell(csN[0]) |-> cmdHeld)
    else $error("command not held one link period");
  AST_CK_HALF: assert property ($changed(ck) |=> $stable(ck) [*3])
    else $error("link clock half period short");
  AST_NO_FIGHT: assert property (!(dqsDOe && dqsCOe))
    else $error("both ends drive the strobe");
  AST_RD_START: assert property ($rose(dqsDOe) |-> dqs)
    else $error("read strobe not high on first beat");
  AST_RD_EDGE: assert property (dqsDOe && $past(dqsDOe) && $changed(dq) |-> $changed(dqs))
    else $error("read data moved without strobe edge");
  AST_WR_MID: assert property (dqsCOe && $past(dqsCOe) && $changed(dqs) |-> $stable(dq))
    else $error("write strobe edge on a data change");
  AST_WR_BEAT: assert property (dqsCOe && $past(dqsCOe) && $changed(dq) |=> $stable(dq) [*3])
    else $error("write beat shorter than half link period");
endmodule
`default_nettype wire

// ### sim/test_dual_rank_ddr3_sdram_interface.sv
// Bench joining both link ends; software orders reach the controller over the register bus.
// Assumes default parameters of both ends and a 25 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module test_dual_rank_ddr3_sdram_interface;
  import drdsi_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
  logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rv, rdata;
  logic [1:0] termDq, termDm, termTdqs, bresp, rresp, rs, bs;
  logic awready, wready, bvalid, arready, rvalid;
  int failures = 0, n_checks = 0, cyc = 0;
  drdsi_if lnk ();
  drdsi_device drdsi_device_i (.clk, .nrst, .link(lnk.dev), .termDq, .termDm, .termTdqs);
  drdsi_ctrl drdsi_ctrl_i (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .link(lnk.ctrl));
  drdsi_props drdsi_props_i (.clk, .nrst, .ck(lnk.ck), .csN(lnk.csN), .dq(lnk.dq), .dqs(lnk.dqs),
    .dqDOe(lnk.dqDOe), .dqsDOe(lnk.dqsDOe), .dqCOe(lnk.dqCOe), .dqsCOe(lnk.dqsCOe));
  always #20 clk = ~clk;
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      close_out();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Bus write: address and data offered together, each dropped once taken
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bs = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata; rs = rresp; rready <= 1'b0;
  endtask
  // One link command, then wait for the sequencer to go idle
  task automatic cmd(logic r, logic [2:0] c, logic [18:0] a);
    wr(8'h04, {13'h0, a});
    wr(8'h00, {27'h0, r, 1'b0, c});
    do rd(8'h18); while (rv[0] !== 1'b0);
  endtask
  // Bank 1, column 0 of the chosen rank
  task automatic put(logic r, logic [63:0] d, logic [7:0] m);
    wr(8'h08, d[31:0]); wr(8'h0c, d[63:32]); wr(8'h10, {24'h0, m});
    cmd(r, CMD_WR, 19'h10000);
  endtask
  task automatic get(logic r, logic [63:0] e, string nm);
    cmd(r, CMD_RD, 19'h10000);
    rd(8'h1c); chk(nm, e[31:0], rv);
    rd(8'h20); chk(nm, e[63:32], rv);
  endtask
  // Idle status after reset, unmapped offset refused
  task automatic s_reg;
    rd(8'h18); chk("busy", 32'h0, rv);
    rd(8'h40); chk("resp", 32'h2, {30'h0, rs});
    wr(8'h40, 32'h0); chk("bresp", 32'h2, {30'h0, bs});
  endtask
  // Full burst, masked beats, and two ranks holding separate data
  task automatic s_data;
    cmd(1'b0, CMD_ACT, 19'h10002);
    put(1'b0, 64'h8877665544332211, 8'h00);
    get(1'b0, 64'h8877665544332211, "r0");
    put(1'b0, 64'hffeeddccbbaa9988, 8'hf0);
    get(1'b0, 64'h88776655bbaa9988, "mask");
    cmd(1'b1, CMD_ACT, 19'h10002);
    put(1'b1, 64'h0123456789abcdef, 8'h00);
    get(1'b1, 64'h0123456789abcdef, "r1");
    get(1'b0, 64'h88776655bbaa9988, "r0 kept");
  endtask
  // Chopped interleaved write at column 1, then a write that a closed bank must drop
  task automatic s_mode;
    wr(8'h14, 32'h4);
    cmd(1'b0, CMD_MRS, 19'h00009);
    wr(8'h08, 32'h44332211);
    cmd(1'b0, CMD_WR, 19'h10001);
    cmd(1'b0, CMD_RD, 19'h11000);
    rd(8'h1c); chk("chop lo", 32'h33441122, rv);
    rd(8'h20); chk("chop hi", 32'h88776655, rv);
    cmd(1'b0, CMD_PRE, 19'h10000);
    cmd(1'b0, CMD_WR, 19'h11000);
    cmd(1'b0, CMD_ACT, 19'h10002);
    cmd(1'b0, CMD_RD, 19'h11400);
    rd(8'h1c); chk("closed", 32'h33441122, rv);
  endtask
  // Termination per rank, then disabled by mode load on rank 0 only
  task automatic s_term;
    wr(8'h14, 32'h1); repeat (24) @(posedge clk);
    chk("term", 32'h5, {26'h0, termTdqs, termDm, termDq});
    cmd(1'b0, CMD_MRS, 19'h10000);
    wr(8'h14, 32'h3); repeat (24) @(posedge clk);
    chk("term off", 32'ha, {26'h0, termTdqs, termDm, termDq});
    // Termination strobe on rank 1: mask pin stops masking
    cmd(1'b1, CMD_MRS, 19'h10804); repeat (24) @(posedge clk);
    chk("tdqs", 32'h22, {26'h0, termTdqs, termDm, termDq});
    put(1'b1, 64'hfedcba9876543210, 8'hff);
    get(1'b1, 64'hfedcba9876543210, "tdqs mask");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    s_reg();
    s_data();
    s_mode();
    s_term();
    close_out();
  end
endmodule
`default_nettype wire
